//--- shared/tpup_regs.vh
// Constants for the TFT pixel unpack and palette stage.
// Included by bare name; holds definitions only.
`ifndef TPUP_REGS_VH
`define TPUP_REGS_VH

// Bits-per-pixel mode codes
`define TPUP_BPP_1          3'h0
`define TPUP_BPP_2          3'h1
`define TPUP_BPP_4          3'h2
`define TPUP_BPP_8          3'h3
`define TPUP_BPP_16         3'h4

// Palette entry formats
`define TPUP_PAL_666        2'h0
`define TPUP_PAL_565        2'h1
`define TPUP_PAL_5551       2'h3

// Direct 16-bit pixel formats
`define TPUP_P16_565        1'h0
`define TPUP_P16_5551       1'h1

// Vertical phase code in which palette access is blocked
`define TPUP_VPHASE_ACTIVE  2'h2

// Field widths and memory sizes
`define TPUP_WORD_W         32
`define TPUP_PIN_W          18
`define TPUP_PAL_W          24
`define TPUP_PAL_DEPTH      256
`define TPUP_PAL_AW         8
`define TPUP_FIFO_DEPTH     4

// Pin reset value and last serial beat index
`define TPUP_PINS_RST       18'h00000
`define TPUP_LAST_BEAT      2'h2

`endif

//--- rtl/tpup_fifo.v
// Word FIFO between frame-buffer fetch and pixel unpacking.
// Assumes producer and consumer share sys_clk; in_ready and out_valid are flops.
`timescale 1ns/10ps
module tpup_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam [AW:0] DEPTH_C = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  reg             full_r;
  reg             empty_r;
  wire            push;
  wire            pop;
  reg [AW:0]      count_nxt;

  assign push      = in_valid & ~full_r;
  assign pop       = out_ready & ~empty_r;
  assign in_ready  = ~full_r;
  assign out_valid = ~empty_r;
  assign out_data  = mem[rd_ptr_r];

  always @* begin
    count_nxt = count_r;
    if (push & ~pop)
      count_nxt = count_r + 1'b1;
    else if (pop & ~push)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge sys_clk) begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
    end else begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH_C[AW-1:0] - 1'b1 && DEPTH_C[AW:0] != (1 << AW)) ?
                    {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH_C[AW-1:0] - 1'b1 && DEPTH_C[AW:0] != (1 << AW)) ?
                    {AW{1'b0}} : rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      full_r  <= (count_nxt == DEPTH_C);
      empty_r <= (count_nxt == {(AW+1){1'b0}});
    end
  end
endmodule

//--- rtl/tpup_palette.v
// Single-port palette memory with registered read data.
// Assumes one access per cycle; the caller arbitrates between users.
`timescale 1ns/10ps
module tpup_palette #(
  parameter WIDTH = 24,
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire [AW-1:0]    addr,
  input  wire             we,
  input  wire [WIDTH-1:0] wdata,
  output reg  [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge sys_clk) begin
    if (we)
      mem[addr] <= wdata;
  end

  always @(posedge sys_clk) begin
    if (srst)
      rdata <= {WIDTH{1'b0}};
    else
      rdata <= mem[addr];
  end
endmodule

//--- rtl/tpup_unpack.v
// Pixel unpack, palette lookup and video pin mapping for a TFT controller.
// Assumes words arrive from a fetch engine on sys_clk; controls are sys_clk levels.
//
// Summary of operation
// [RULE_01] 16bpp: upper half first; halfword swap reverses
// [RULE_02] 16bpp decode 5:6:5 or 5:5:5 plus intensity
// [RULE_03] 16bpp parallel pin map, intensity on 12/6/0
// [RULE_04] 16bpp serial: red, green, blue beats, pins 17:12
// [RULE_05] 8bpp: four pixels from top byte down
// [RULE_06] Byte swap reverses bytes, keeps nibble order
// [RULE_07] Direct 8bpp: red 7:5, green 4:2, blue 1:0
// [RULE_08] Direct 8bpp parallel on pins 17:15, 11:9, 5:4
// [RULE_09] Direct 8bpp serial: three left-aligned beats
// [RULE_10] 4bpp: eight pixels from top nibble down
// [RULE_11] 2bpp: sixteen pixels from top pair down
// [RULE_12] Palette of 256 by 24 bits, pixel indexed
// [RULE_13] Palette formats 6:6:6, 5:6:5, 5:5:5:1
// [RULE_14] Intensity bit is shared colour LSB
// [RULE_15] Software writes format 3 after loading palette
// [RULE_16] 6:6:6 entry bits 17:0 drive pins directly
// [RULE_17] 5:6:5 entry routed to pins 17:13, 11:6, 5:1
// [RULE_18] Low depths palettized; 8 and 16 direct (8bpp here indexes the palette when palette_enable is set)
// [RULE_19] No palette access during active display
// [RULE_20] Untabulated swap cases reverse bytes, keep pixels
`timescale 1ns/10ps
`include "tpup_regs.vh"
module tpup_unpack #(
  parameter FIFO_DEPTH = `TPUP_FIFO_DEPTH
) (
  input  wire                       sys_clk,
  input  wire                       srst,
  input  wire [`TPUP_WORD_W-1:0]    word_data,
  input  wire                       word_valid,
  output wire                       word_ready,
  input  wire [2:0]                 bpp_mode,
  input  wire                       palette_enable,
  input  wire                       pix16_format,
  input  wire                       serial_mode,
  input  wire                       byte_swap_enable,
  input  wire                       halfword_swap_enable,
  input  wire [1:0]                 palette_format_select,
  input  wire [1:0]                 vertical_phase_state,
  input  wire                       pal_cpu_en,
  input  wire                       pal_cpu_we,
  input  wire [`TPUP_PAL_AW-1:0]    pal_cpu_addr,
  input  wire [`TPUP_PAL_W-1:0]     pal_cpu_wdata,
  output wire [`TPUP_PAL_W-1:0]     pal_cpu_rdata,
  output reg                        pal_cpu_ack_r,
  output reg  [`TPUP_PIN_W-1:0]     video_data_pins_r,
  output reg                        video_valid_r,
  output reg  [1:0]                 video_beat_r,
  input  wire                       video_ready
);
  localparam [3:0] S_FETCH = 4'b0001;
  localparam [3:0] S_PIX   = 4'b0010;
  localparam [3:0] S_LOOK  = 4'b0100;
  localparam [3:0] S_EMIT  = 4'b1000;

  reg  [3:0]               state_r;
  reg  [`TPUP_WORD_W-1:0]  shift_r;
  reg  [5:0]               left_r;
  reg  [15:0]              pix_r;
  reg                      use_pal_r;
  reg  [5:0]               beat1_r;
  reg  [5:0]               beat2_r;

  wire [`TPUP_WORD_W-1:0]  fifo_data;
  wire                     fifo_valid;
  wire                     fifo_pop;
  wire [`TPUP_PAL_W-1:0]   pal_rdata;
  wire                     use_pal;
  wire                     lookup;
  wire                     cpu_grant;
  wire [`TPUP_PAL_AW-1:0]  pal_addr;

  reg  [`TPUP_WORD_W-1:0]  swapped;
  reg  [15:0]              pix_now;
  reg  [5:0]               per_word;
  reg  [`TPUP_PAL_W-1:0]   src;
  reg  [17:0]              par;
  reg  [5:0]               b0;
  reg  [5:0]               b1;
  reg  [5:0]               b2;
  reg                      inten;

  tpup_fifo #(
    .WIDTH (`TPUP_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = (state_r == S_FETCH);

  // Depths below 8 always index the palette; 8bpp does so only when enabled
  assign use_pal = (bpp_mode == `TPUP_BPP_1) | (bpp_mode == `TPUP_BPP_2) |   // RULE_18
                   (bpp_mode == `TPUP_BPP_4) |
                   ((bpp_mode == `TPUP_BPP_8) & palette_enable);

  // Pixel lookups own the single port; software is held off in the active phase
  assign lookup    = (state_r == S_PIX) & use_pal;
  assign cpu_grant = pal_cpu_en & ~lookup &
                     (vertical_phase_state != `TPUP_VPHASE_ACTIVE);           // RULE_19
  assign pal_addr  = lookup ? pix_now[`TPUP_PAL_AW-1:0] : pal_cpu_addr;       // RULE_12
  assign pal_cpu_rdata = pal_rdata;

  tpup_palette #(
    .WIDTH (`TPUP_PAL_W),
    .DEPTH (`TPUP_PAL_DEPTH),
    .AW    (`TPUP_PAL_AW)
  ) u_palette (
    .sys_clk (sys_clk),
    .srst    (srst),
    .addr    (pal_addr),
    .we      (cpu_grant & pal_cpu_we),
    .wdata   (pal_cpu_wdata),
    .rdata   (pal_rdata)
  );

  // Word reordering ahead of MSB-first extraction
  always @* begin
    swapped = fifo_data;
    if (bpp_mode == `TPUP_BPP_16 && halfword_swap_enable && !byte_swap_enable)
      swapped = {fifo_data[15:0], fifo_data[31:16]};                           // RULE_01
    else if (byte_swap_enable || halfword_swap_enable)
      swapped = {fifo_data[7:0], fifo_data[15:8],
                 fifo_data[23:16], fifo_data[31:24]};                           // RULE_06 RULE_20
  end

  always @* begin
    case (bpp_mode)
      `TPUP_BPP_1:  per_word = 6'd32;
      `TPUP_BPP_2:  per_word = 6'd16;                                          // RULE_11
      `TPUP_BPP_4:  per_word = 6'd8;                                           // RULE_10
      `TPUP_BPP_8:  per_word = 6'd4;                                           // RULE_05
      default:      per_word = 6'd2;                                           // RULE_01
    endcase
  end

  // Current pixel always sits in the top bits of the shift register
  always @* begin
    case (bpp_mode)
      `TPUP_BPP_1:  pix_now = {15'h0000, shift_r[31]};
      `TPUP_BPP_2:  pix_now = {14'h0000, shift_r[31:30]};                      // RULE_11
      `TPUP_BPP_4:  pix_now = {12'h000, shift_r[31:28]};                       // RULE_10
      `TPUP_BPP_8:  pix_now = {8'h00, shift_r[31:24]};                         // RULE_05
      default:      pix_now = shift_r[31:16];                                  // RULE_01
    endcase
  end

  // Colour composition into the parallel word and the three serial beats
  always @* begin
    src   = use_pal_r ? pal_rdata : {8'h00, pix_r};
    inten = src[0];
    par   = `TPUP_PINS_RST;
    b0    = 6'h00;
    b1    = 6'h00;
    b2    = 6'h00;
    if (!use_pal_r && bpp_mode == `TPUP_BPP_8) begin
      par = {src[7:5], 3'b000, src[4:2], 3'b000, src[1:0], 4'h0};              // RULE_07 RULE_08
      b0  = {src[7:5], 3'b000};                                                // RULE_09
      b1  = {src[4:2], 3'b000};                                                // RULE_09
      b2  = {src[1:0], 4'h0};                                                  // RULE_09
    end else if (use_pal_r && palette_format_select != `TPUP_PAL_565 &&       // RULE_13
                 palette_format_select != `TPUP_PAL_5551) begin
      par = src[17:0];                                                         // RULE_16
      b0  = src[17:12];
      b1  = src[11:6];
      b2  = src[5:0];
    end else if ((use_pal_r && palette_format_select == `TPUP_PAL_5551) ||
                 (!use_pal_r && pix16_format == `TPUP_P16_5551)) begin
      par = {src[15:11], inten, src[10:6], inten, src[5:1], inten};            // RULE_02 RULE_03
      b0  = {src[15:11], inten};                                               // RULE_04 RULE_14
      b1  = {src[10:6], inten};                                                // RULE_04 RULE_14
      b2  = {src[5:1], inten};                                                 // RULE_04 RULE_14
    end else begin
      par = {src[15:11], 1'b0, src[10:5], src[4:0], 1'b0};                     // RULE_02 RULE_03 RULE_17
      b0  = {src[15:11], 1'b0};                                                // RULE_04
      b1  = src[10:5];                                                         // RULE_04
      b2  = {src[4:0], 1'b0};                                                  // RULE_04
    end
  end
  // Format code 3 is only meaningful once the table is loaded; entries are
  // read per pixel so a late format write takes effect on the next pixel.  // RULE_13 RULE_15

  always @(posedge sys_clk) begin
    if (srst) begin
      state_r           <= S_FETCH;
      shift_r           <= 32'h00000000;
      left_r            <= 6'h00;
      pix_r             <= 16'h0000;
      use_pal_r         <= 1'b0;
      beat1_r           <= 6'h00;
      beat2_r           <= 6'h00;
      video_data_pins_r <= `TPUP_PINS_RST;
      video_valid_r     <= 1'b0;
      video_beat_r      <= 2'h0;
      pal_cpu_ack_r     <= 1'b0;
    end else begin
      pal_cpu_ack_r <= cpu_grant;
      case (state_r)
        S_FETCH: begin
          if (fifo_valid) begin
            shift_r <= swapped;
            left_r  <= per_word;
            state_r <= S_PIX;
          end
        end
        S_PIX: begin
          pix_r     <= pix_now;
          use_pal_r <= use_pal;
          state_r   <= S_LOOK;
        end
        S_LOOK: begin
          // Palette data for the lookup issued in S_PIX is valid here
          video_data_pins_r <= serial_mode ? {b0, 12'h000} : par;              // RULE_04 RULE_09
          beat1_r           <= b1;
          beat2_r           <= b2;
          video_valid_r     <= 1'b1;
          video_beat_r      <= 2'h0;
          state_r           <= S_EMIT;
        end
        S_EMIT: begin
          if (video_ready) begin
            if (serial_mode && video_beat_r != `TPUP_LAST_BEAT) begin
              video_data_pins_r <= {((video_beat_r == 2'h0) ? beat1_r : beat2_r),
                                    12'h000};                                  // RULE_04 RULE_09
              video_beat_r      <= video_beat_r + 2'h1;
            end else begin
              video_valid_r <= 1'b0;
              video_beat_r  <= 2'h0;
              if (left_r == 6'h01) begin
                state_r <= S_FETCH;
              end else begin
                left_r <= left_r - 6'h01;
                case (bpp_mode)
                  `TPUP_BPP_1: shift_r <= {shift_r[30:0], 1'b0};
                  `TPUP_BPP_2: shift_r <= {shift_r[29:0], 2'b00};              // RULE_11
                  `TPUP_BPP_4: shift_r <= {shift_r[27:0], 4'h0};               // RULE_10
                  `TPUP_BPP_8: shift_r <= {shift_r[23:0], 8'h00};              // RULE_05
                  default:     shift_r <= {shift_r[15:0], 16'h0000};           // RULE_01
                endcase
                state_r <= S_PIX;
              end
            end
          end
        end
        default: state_r <= S_FETCH;
      endcase
    end
  end
endmodule

//--- verification/tpup_unpack_sva.sv
// Checker for the pixel unpack stage: pin mapping, beat order, palette grant.
// Sees only tpup_unpack ports; controls are changed only while the pipe is idle.
`timescale 1ns/10ps
module tpup_unpack_sva #(
  parameter FIFO_DEPTH = 4
) (
  input wire        sys_clk,
  input wire        srst,
  input wire [2:0]  bpp_mode,
  input wire        palette_enable,
  input wire        pix16_format,
  input wire        serial_mode,
  input wire [1:0]  vertical_phase_state,
  input wire        pal_cpu_en,
  input wire        pal_cpu_ack_r,
  input wire [17:0] video_data_pins_r,
  input wire        video_valid_r,
  input wire [1:0]  video_beat_r,
  input wire        video_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire par = video_valid_r && !serial_mode;
  wire ser = video_valid_r && serial_mode;
  wire d16 = bpp_mode == 3'h4;
  property p_hold;
    video_valid_r && !video_ready |=> video_valid_r && $stable(video_data_pins_r)
      && $stable(video_beat_r);
  endproperty
  property p_next;
    ser && video_ready && video_beat_r != 2'h2 |=>
      video_valid_r && video_beat_r == $past(video_beat_r) + 2'h1;
  endproperty
  property p_par0;
    par |-> video_beat_r == 2'h0;
  endproperty
  property p_565;
    par && d16 && !pix16_format |-> !video_data_pins_r[12] && !video_data_pins_r[0];
  endproperty
  property p_5551;
    par && d16 && pix16_format |-> video_data_pins_r[12] == video_data_pins_r[6]
      && video_data_pins_r[0] == video_data_pins_r[6];
  endproperty
  property p_ser_lo;
    ser |-> video_data_pins_r[11:0] == 12'h000;
  endproperty
  property p_ser565;
    ser && d16 && !pix16_format && video_beat_r != 2'h1 |-> !video_data_pins_r[12];
  endproperty
  property p_332;
    par && bpp_mode == 3'h3 && !palette_enable |-> video_data_pins_r[14:12] == 3'h0
      && video_data_pins_r[8:6] == 3'h0 && video_data_pins_r[3:0] == 4'h0;
  endproperty
  property p_blk;
    pal_cpu_en && vertical_phase_state == 2'h2 |=> !pal_cpu_ack_r;
  endproperty
  property p_ack;
    pal_cpu_ack_r |-> $past(pal_cpu_en) && $past(vertical_phase_state) != 2'h2;
  endproperty
  a_hold: assert property (p_hold) else $error("beat changed while stalled");
  a_next: assert property (p_next) else $error("serial beat out of order");
  a_par0: assert property (p_par0) else $error("parallel beat index not zero");
  a_565: assert property (p_565) else $error("565 unused pins driven");
  a_5551: assert property (p_5551) else $error("intensity pins differ");
  a_ser_lo: assert property (p_ser_lo) else $error("serial low pins driven");
  a_ser565: assert property (p_ser565) else $error("serial 565 pin 12 driven");
  a_332: assert property (p_332) else $error("332 unused pins driven");
  a_blk: assert property (p_blk) else $error("palette access granted in active phase");
  a_ack: assert property (p_ack) else $error("ack without granted request");
  c_ser2: cover property (ser && video_ready && video_beat_r == 2'h2);
  c_blk: cover property (pal_cpu_en && vertical_phase_state == 2'h2);
  c_stall: cover property (video_valid_r && !video_ready);
endmodule
bind tpup_unpack tpup_unpack_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.sys_clk, .srst,
  .bpp_mode, .palette_enable, .pix16_format, .serial_mode, .vertical_phase_state,
  .pal_cpu_en, .pal_cpu_ack_r, .video_data_pins_r, .video_valid_r, .video_beat_r,
  .video_ready);

//--- verification/tpup_panel_model.sv
// Panel model: takes beats on valid and ready, keeps them in order.
// Ready changes just after the clock edge; hold stalls it, slow halves it.
`timescale 1ns/10ps
module tpup_panel_model (
  input wire         sys_clk,
  input wire         srst,
  input wire  [17:0] video_data_pins_r,
  input wire         video_valid_r,
  input wire  [1:0]  video_beat_r,
  input wire         hold,
  input wire         slow,
  output logic       video_ready = 1'h0
);
  logic [17:0] rxq[$];
  logic        tog = 1'h0;
  always @(posedge sys_clk) begin
    if (video_valid_r && video_ready && !srst)
      rxq.push_back(video_data_pins_r);
    tog <= ~tog;
    video_ready <= !srst && !hold && (!slow || tog);
  end
endmodule

//--- verification/tb_tpup_unpack.sv
// Bench for tpup_unpack: palette access, word unpack, swaps and pin mapping.
// Panel model collects beats; controls change only while the pipe is idle.
`timescale 1ns/10ps
module tb_tpup_unpack;
  logic        sys_clk = 1'h0, srst = 1'h1, word_valid = 1'h0, hold = 1'h0, slow = 1'h0;
  logic [31:0] word_data = 32'h0;
  logic [2:0]  bpp_mode = 3'h4;
  logic        palette_enable = 1'h0, pix16_format = 1'h0, serial_mode = 1'h0;
  logic        byte_swap_enable = 1'h0, halfword_swap_enable = 1'h0;
  logic [1:0]  palette_format_select = 2'h0, vertical_phase_state = 2'h0;
  logic        pal_cpu_en = 1'h0, pal_cpu_we = 1'h0;
  logic [7:0]  pal_cpu_addr = 8'h0;
  logic [23:0] pal_cpu_wdata = 24'h0, pal_cpu_rdata;
  logic        word_ready, pal_cpu_ack_r, video_valid_r, video_ready;
  logic [17:0] video_data_pins_r;
  logic [1:0]  video_beat_r;
  logic [23:0] pal_m [256];
  logic [17:0] expq[$];
  int          err_count = 0, n_compared = 0, cyc = 0, i;
  tpup_unpack #(.FIFO_DEPTH(4)) dut (.sys_clk, .srst, .word_data, .word_valid,
    .word_ready, .bpp_mode, .palette_enable, .pix16_format, .serial_mode,
    .byte_swap_enable, .halfword_swap_enable, .palette_format_select,
    .vertical_phase_state, .pal_cpu_en, .pal_cpu_we, .pal_cpu_addr, .pal_cpu_wdata,
    .pal_cpu_rdata, .pal_cpu_ack_r, .video_data_pins_r, .video_valid_r,
    .video_beat_r, .video_ready);
  tpup_panel_model panel (.sys_clk, .srst, .video_data_pins_r, .video_valid_r,
    .video_beat_r, .hold, .slow, .video_ready);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task finish_test;
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Kinds: 0 is 5:6:5, 1 is 5:5:5 plus intensity, 2 is 3:3:2
  function logic [17:0] map(input logic [15:0] p, input logic [1:0] k);
    case (k)
      2'h0: map = {p[15:11], 1'h0, p[10:5], p[4:0], 1'h0};
      2'h1: map = {p[15:11], p[0], p[10:6], p[0], p[5:1], p[0]};
      default: map = {p[7:5], 3'h0, p[4:2], 3'h0, p[1:0], 4'h0};
    endcase
  endfunction
  task pal(input logic we, input logic [7:0] a, input logic [23:0] d, input logic ok);
    pal_cpu_we = we;
    pal_cpu_addr = a;
    pal_cpu_wdata = d;
    pal_cpu_en = 1'h1;
    @(negedge sys_clk);
    pal_cpu_en = 1'h0;
    check(pal_cpu_ack_r, ok);
    if (ok && !we) check(pal_cpu_rdata, pal_m[a]);
    if (ok && we) pal_m[a] = d;
    @(negedge sys_clk);
  endtask
  // Queues the expected beats of one word, then offers it until taken
  task go(input logic [31:0] w);
    int n, b, k, t;
    logic [31:0] s;
    logic [15:0] p;
    logic [23:0] e;
    logic [17:0] v;
    b = 1 << bpp_mode;
    s = (byte_swap_enable || (halfword_swap_enable && b != 16)) ?
      {w[7:0], w[15:8], w[23:16], w[31:24]} : halfword_swap_enable ? {w[15:0], w[31:16]} : w;
    for (n = 0; n < 32 / b; n++) begin
      p = s >> (32 - b * (n + 1));
      if (b < 16) p = p & ~(16'hffff << b);
      e = pal_m[p[7:0]];
      if (b == 16) v = map(p, {1'h0, pix16_format});
      else if (b == 8 && !palette_enable) v = map(p, 2'h2);
      else if (palette_format_select == 2'h3) v = map(e[15:0], 2'h1);
      else if (palette_format_select == 2'h1) v = map(e[15:0], 2'h0);
      else v = e[17:0];
      for (k = 0; k < (serial_mode ? 3 : 1); k++)
        expq.push_back(serial_mode ? {v[17 - 6 * k -: 6], 12'h0} : v);
    end
    word_data = w;
    word_valid = 1'h1;
    for (t = 0; t < 400 && word_ready !== 1'h1; t++) @(negedge sys_clk);
    if (t == 400) err_count++;
    @(negedge sys_clk);
  endtask
  task drain;
    int t;
    word_valid = 1'h0;
    for (t = 0; t < 3000 && panel.rxq.size() < expq.size(); t++) @(negedge sys_clk);
    repeat (6) @(negedge sys_clk);
    check(24'(panel.rxq.size()), 24'(expq.size()));
    while (expq.size() > 0 && panel.rxq.size() > 0)
      check(panel.rxq.pop_front(), expq.pop_front());
    expq = {};
    panel.rxq = {};
  endtask
  task run(input logic s, w, b, h, input logic [1:0] f, input logic e, p,
           input logic [2:0] m);
    serial_mode = s;
    slow = w;
    byte_swap_enable = b;
    halfword_swap_enable = h;
    palette_format_select = f;
    palette_enable = e;
    pix16_format = p;
    bpp_mode = m;
    @(negedge sys_clk);
    go(32'h8e3f_71c2);
    go(32'h05fa_e91b);
    drain;
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 1'h0;
    @(negedge sys_clk);
    for (i = 0; i < 256; i++)
      pal(1'h1, i[7:0], {i[7:0] ^ 8'h5a, ~i[7:0], i[7:0] * 8'h1d}, 1'h1);
    for (i = 3; i < 256; i += 50) pal(1'h0, i[7:0], 24'h0, 1'h1);
    vertical_phase_state = 2'h2;
    pal(1'h1, 8'h05, 24'h123456, 1'h0);
    vertical_phase_state = 2'h0;
    pal(1'h0, 8'h05, 24'h0, 1'h1);
    run(1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 3'h4);
    hold = 1'h1;
    for (i = 0; i < 5; i++) go(32'h1357_9bdf + i);
    word_valid = 1'h0;
    @(negedge sys_clk);
    check(word_ready, 1'h0);
    hold = 1'h0;
    drain;
    run(1'h0, 1'h0, 1'h0, 1'h1, 2'h0, 1'h0, 1'h1, 3'h4);
    run(1'h1, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 3'h4);
    run(1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 3'h4);
    run(1'h0, 1'h0, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 3'h4);
    run(1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 3'h3);
    run(1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 3'h3);
    run(1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 3'h3);
    run(1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0, 3'h3);
    run(1'h0, 1'h0, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0, 3'h2);
    run(1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 3'h2);
    run(1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 3'h1);
    run(1'h0, 1'h0, 1'h0, 1'h1, 2'h0, 1'h0, 1'h0, 3'h1);
    run(1'h1, 1'h1, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0, 3'h1);
    finish_test();
  end
endmodule
